// file: dv/asr_core_asserts.sv
// Port-level assertions for the serial transceiver core
`timescale 1ns/1ps
module asr_core_checker (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic tx_enable,
    input wire logic rx_enable,
    input wire logic tx_polarity_invert,
    input wire logic data_buffer_port_write,
    input wire logic data_buffer_port_read,
    input wire logic [7:0] data_buffer_port_rdata,
    input wire logic tx_buffer_empty,
    input wire logic tx_complete,
    input wire logic rx_buffer_full,
    input wire logic overrun_flag,
    input wire logic noise_flag,
    input wire logic framing_error_flag,
    input wire logic txd,
    input wire logic txd_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    chk_reset_flags: assert property ($rose(nrst) |-> tx_buffer_empty && tx_complete)
        else $error("transmit flags wrong after reset");
    chk_write_fills: assert property (data_buffer_port_write |=> !tx_buffer_empty)
        else $error("buffer empty flag kept after write");
    chk_idle_high: assert property (tx_complete && txd_oe && $stable(tx_polarity_invert)
        |-> txd == !tx_polarity_invert)
        else $error("idle output level wrong");
    chk_rx_off: assert property (!rx_enable [*3] |=> !$rose(rx_buffer_full))
        else $error("disabled receiver filled buffer");
    chk_fe_blocks: assert property (framing_error_flag && $past(framing_error_flag)
        |-> !$rose(rx_buffer_full))
        else $error("transfer while framing error set");
    chk_overrun_keeps: assert property ($rose(overrun_flag)
        |-> rx_buffer_full && $stable(data_buffer_port_rdata))
        else $error("overrun changed buffered data");
    chk_full_clear: assert property ($fell(rx_buffer_full) |-> $past(data_buffer_port_read))
        else $error("full flag cleared without data read");
    chk_noise_xfer: assert property ($rose(noise_flag) |-> $rose(rx_buffer_full))
        else $error("noise flag outside transfer");
    chk_release_done: assert property ($fell(txd_oe) |-> !tx_enable && tx_complete)
        else $error("pin released while busy");
    cover property ($rose(overrun_flag));
    cover property ($rose(framing_error_flag));
    cover property ($fell(txd_oe));
endmodule
bind asr_core asr_core_checker asr_core_checker_inst (
    .mclk, .nrst, .tx_enable, .rx_enable, .tx_polarity_invert, .data_buffer_port_write,
    .data_buffer_port_read, .data_buffer_port_rdata, .tx_buffer_empty, .tx_complete,
    .rx_buffer_full, .overrun_flag, .noise_flag, .framing_error_flag, .txd, .txd_oe
);

// file: dv/asr_remote.sv
// Behavioural remote serial station on the core's serial lines
`timescale 1ns/1ps
module asr_remote #(
    parameter int BIT_CLKS = 64
) (
    input wire logic mclk,
    input wire logic txd,
    input wire logic nine,
    output logic rxd,
    output logic got,
    output logic [8:0] got_data
);
    logic [9:0] sh;
    int n;
    initial begin
        rxd = 1'b1;
        got = 1'b0;
        got_data = 9'h000;
    end
    // Mid-bit sampling; a low stop (break) is never reported as data
    always begin
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge mclk);
        if (txd === 1'b0) begin
            n = nine ? 10 : 9;
            for (int i = 0; i < n; i++) begin
                repeat (BIT_CLKS) @(posedge mclk);
                sh[i] = txd;
            end
            if (sh[n - 1] === 1'b1) begin
                got_data = nine ? sh[8:0] : {1'b0, sh[7:0]};
                @(negedge mclk);
                got = 1'b1;
                @(negedge mclk);
                got = 1'b0;
            end
        end
    end
    task automatic send(input logic [8:0] d, input int nb, input logic stop,
        input logic inv, input int gl);
        logic [10:0] f;
        f = 11'h000;
        for (int i = 0; i < nb; i++) f[i + 1] = d[i];
        f[nb + 1] = stop;
        for (int i = 0; i <= nb + 2; i++) begin
            for (int j = 0; j < BIT_CLKS; j++) begin
                @(negedge mclk);
                // Short pulse on the middle vote slot upsets one sample only
                rxd = (i > nb + 1 ? 1'b1 : f[i]) ^ inv ^ (i == gl && j >= 31 && j < 35);
            end
        end
    endtask
endmodule

// file: dv/tb_asr_core.sv
// Self-checking bench for the serial transceiver core
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("mismatch at %0t: %h vs %h", $time, (a), (e)); end end
`define WAITF(c, lim) for (int w = 0; w < (lim) && !(c); w++) @(negedge mclk);
module tb_asr_core;
    localparam int BIT = 64;
    logic mclk, nrst, tx_enable, rx_enable, tx_polarity_invert, rx_polarity_invert;
    logic nine_bit_select, long_break_select, send_break, ninth_tx_bit;
    logic data_buffer_port_write, data_buffer_port_read, status_one_reg_read, error_clear;
    logic [12:0] baud_div;
    logic [7:0] data_buffer_port_wdata, data_buffer_port_rdata;
    logic ninth_rx_bit, tx_buffer_empty, tx_complete, rx_buffer_full, overrun_flag;
    logic noise_flag, framing_error_flag, txd, txd_oe, rxd, line_tx, got, full_d, watch_rx;
    logic held;
    logic [8:0] got_data, e, d;
    logic [8:0] exp_tx[$], exp_rx[$];
    int total_checks = 0, n_mismatch = 0, cnt;
    asr_core #(.BAUD_DIV_DEFAULT(13'h0001)) asr_core_inst (
        .mclk, .nrst, .baud_div, .tx_enable, .rx_enable, .tx_polarity_invert,
        .rx_polarity_invert, .nine_bit_select, .long_break_select, .send_break, .ninth_tx_bit,
        .data_buffer_port_wdata, .data_buffer_port_write, .data_buffer_port_read,
        .status_one_reg_read, .error_clear, .data_buffer_port_rdata, .ninth_rx_bit,
        .tx_buffer_empty, .tx_complete, .rx_buffer_full, .overrun_flag, .noise_flag,
        .framing_error_flag, .rx_active(), .txd, .txd_oe, .rxd
    );
    // Released pin is driven high by the port, so the line still looks idle
    assign line_tx = txd_oe ? txd : 1'b1;
    asr_remote #(.BIT_CLKS(BIT)) asr_remote_inst (
        .mclk, .txd(line_tx), .nine(nine_bit_select), .rxd, .got, .got_data
    );
    always #5 mclk = ~mclk;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic pulse(ref logic s);
        @(negedge mclk);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask
    task automatic write_tx(input logic [8:0] v);
        `WAITF(tx_buffer_empty === 1'b1, 2000)
        `CHK(tx_buffer_empty, 1'b1)
        ninth_tx_bit = v[8];
        data_buffer_port_wdata = v[7:0];
        exp_tx.push_back({v[8] & nine_bit_select, v[7:0]});
        pulse(data_buffer_port_write);
    endtask
    task automatic wait_tc;
        repeat (100) @(negedge mclk);
        `WAITF(tx_complete === 1'b1, 3000)
        `CHK(tx_complete, 1'b1)
    endtask
    task automatic clear_rx;
        pulse(status_one_reg_read);
        pulse(data_buffer_port_read);
    endtask
    task automatic recv(input logic [8:0] v, input logic stop, input int gl, input logic push);
        if (push) exp_rx.push_back({v[8] & nine_bit_select, v[7:0]});
        asr_remote_inst.send(v, nine_bit_select ? 9 : 8, stop, rx_polarity_invert, gl);
    endtask
    always @(posedge mclk) begin
        if (got === 1'b1) begin
            e = exp_tx.pop_front();
            `CHK(got_data, e)
        end
        if (watch_rx && rx_buffer_full === 1'b1 && full_d === 1'b0) begin
            e = exp_rx.pop_front();
            `CHK({ninth_rx_bit & nine_bit_select, data_buffer_port_rdata}, e)
        end
        full_d <= rx_buffer_full;
    end
    initial begin
        repeat (60000) @(posedge mclk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        {tx_enable, rx_enable, tx_polarity_invert, rx_polarity_invert} = 4'h0;
        {nine_bit_select, long_break_select, send_break, ninth_tx_bit} = 4'h0;
        {data_buffer_port_write, data_buffer_port_read, status_one_reg_read, error_clear} = 4'h0;
        baud_div = 13'h0001;
        data_buffer_port_wdata = 8'h00;
        full_d = 1'b0;
        watch_rx = 1'b1;
        void'($urandom(83459));
        repeat (10) @(negedge mclk);
        nrst = 1'b1;
        @(negedge mclk);
        `CHK(txd, 1'b1)
        `CHK(tx_complete, 1'b1)
        tx_enable = 1'b1;
        rx_enable = 1'b1;
        repeat (70) @(negedge mclk);
        `CHK(tx_complete, 1'b0)
        `CHK(txd, 1'b1)
        for (int m = 0; m < 2; m++) begin
            nine_bit_select = m[0];
            repeat (3) write_tx(9'($urandom));
            wait_tc();
        end
        nine_bit_select = 1'b0;
        write_tx(9'($urandom));
        `WAITF(tx_buffer_empty === 1'b1, 200)
        tx_enable = 1'b0;
        repeat (100) @(negedge mclk);
        `CHK(txd_oe, 1'b1)
        wait_tc();
        repeat (2) @(negedge mclk);
        `CHK(txd_oe, 1'b0)
        tx_enable = 1'b1;
        write_tx(9'($urandom));
        `WAITF(tx_buffer_empty === 1'b1, 2000)
        tx_enable = 1'b0;
        @(negedge mclk);
        tx_enable = 1'b1;
        repeat (900) @(negedge mclk);
        `CHK(tx_complete, 1'b0)
        wait_tc();
        for (int k = 0; k < 4; k++) begin
            {long_break_select, nine_bit_select} = k[1:0];
            held = (k == 2);
            send_break = 1'b1;
            @(negedge mclk);
            send_break = 1'b0;
            @(negedge mclk);
            send_break = held;
            `WAITF(txd === 1'b0, 1000)
            for (cnt = 0; cnt < 4000 && txd === 1'b0; cnt++) begin
                @(negedge mclk);
                if (cnt == BIT) send_break = 1'b0;
            end
            `CHK(cnt, (10 + k[0] + 3 * k[1]) * BIT * (held ? 2 : 1))
            wait_tc();
        end
        {long_break_select, nine_bit_select} = 2'h0;
        tx_polarity_invert = 1'b1;
        repeat (3) @(negedge mclk);
        `CHK(txd, 1'b0)
        tx_polarity_invert = 1'b0;
        repeat (700) @(negedge mclk);
        d = 9'($urandom);
        recv(d, 1'b1, -1, 1'b1);
        pulse(data_buffer_port_read);
        `CHK(rx_buffer_full, 1'b1)
        clear_rx();
        `CHK(rx_buffer_full, 1'b0)
        recv(d, 1'b1, -1, 1'b1);
        recv(~d, 1'b1, -1, 1'b0);
        `CHK(overrun_flag, 1'b1)
        `CHK(data_buffer_port_rdata, d[7:0])
        clear_rx();
        `CHK(overrun_flag, 1'b0)
        nine_bit_select = 1'b1;
        recv(9'($urandom), 1'b1, -1, 1'b1);
        clear_rx();
        nine_bit_select = 1'b0;
        // Glitched bit is a zero, so the glitch never forms a falling edge
        recv(9'($urandom) & 9'h1f7, 1'b1, 4, 1'b1);
        `CHK(noise_flag, 1'b1)
        clear_rx();
        watch_rx = 1'b0;
        recv(9'h0a5, 1'b0, -1, 1'b0);
        `CHK(framing_error_flag, 1'b1)
        clear_rx();
        recv(9'h05a, 1'b1, -1, 1'b0);
        `CHK(rx_buffer_full, 1'b0)
        // Early restart after the framing error may still be inside a false frame
        repeat (12 * BIT) @(negedge mclk);
        pulse(error_clear);
        watch_rx = 1'b1;
        recv(9'($urandom), 1'b1, -1, 1'b1);
        clear_rx();
        rx_enable = 1'b0;
        recv(9'($urandom), 1'b1, -1, 1'b0);
        `CHK(rx_buffer_full, 1'b0)
        rx_polarity_invert = 1'b1;
        asr_remote_inst.rxd = 1'b0;
        repeat (4) @(negedge mclk);
        rx_enable = 1'b1;
        repeat (BIT) @(negedge mclk);
        recv(9'($urandom), 1'b1, -1, 1'b1);
        clear_rx();
        `CHK(exp_rx.size() + exp_tx.size(), 0)
        report_and_stop();
    end
endmodule

// file: verilog/asr_baud_gen.sv
// Shared baud generator: clock divided by four, then by the modulo divisor
`timescale 1ns/1ps
module asr_baud_gen (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [12:0] baud_div,
    asr_tick_if.gen ticks
);
    logic [1:0] pre_q;
    logic [12:0] div_q;
    logic [3:0] sub_q;
    logic pre_tick;

    assign pre_tick = (pre_q == 2'(asr_pkg::PRESCALE - 1));

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pre_q <= 2'h0;
        end else begin
            pre_q <= pre_q + 2'h1;
        end
    end

    // A zero divisor is treated as one so the ticks never stop
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            div_q <= 13'h0000;
            ticks.tick16 <= 1'b0;
        end else begin
            ticks.tick16 <= 1'b0;
            if (pre_tick) begin
                if (div_q + 13'h0001 >= baud_div) begin
                    div_q <= 13'h0000;
                    ticks.tick16 <= 1'b1;
                end else begin
                    div_q <= div_q + 13'h0001;
                end
            end
        end
    end

    // Transmit bit clock is one in sixteen of the same ticks
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sub_q <= 4'h0;
            ticks.tick1_tx <= 1'b0;
        end else begin
            ticks.tick1_tx <= 1'b0;
            if (ticks.tick16) begin
                sub_q <= sub_q + 4'h1;
                ticks.tick1_tx <= (sub_q == asr_pkg::SLOT_LAST);
            end
        end
    end
endmodule

// file: verilog/asr_core.sv
// Full-duplex asynchronous serial transmitter and receiver core
`timescale 1ns/1ps
module asr_core #(
    parameter logic [12:0] BAUD_DIV_DEFAULT = asr_pkg::BAUD_DIV_RESET
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [12:0] baud_div,
    input wire logic tx_enable,
    input wire logic rx_enable,
    input wire logic tx_polarity_invert,
    input wire logic rx_polarity_invert,
    input wire logic nine_bit_select,
    input wire logic long_break_select,
    input wire logic send_break,
    input wire logic ninth_tx_bit,
    input wire logic [7:0] data_buffer_port_wdata,
    input wire logic data_buffer_port_write,
    input wire logic data_buffer_port_read,
    input wire logic status_one_reg_read,
    input wire logic error_clear,
    output logic [7:0] data_buffer_port_rdata,
    output logic ninth_rx_bit,
    output logic tx_buffer_empty,
    output logic tx_complete,
    output logic rx_buffer_full,
    output logic overrun_flag,
    output logic noise_flag,
    output logic framing_error_flag,
    output logic rx_active,
    output logic txd,
    output logic txd_oe,
    input wire logic rxd
);
    initial begin
        if (BAUD_DIV_DEFAULT == 13'h0000) begin
            $error("baud divisor default must be nonzero");
        end
    end

    asr_tick_if ticks ();

    asr_baud_gen u_baud (
        .mclk(mclk),
        .nrst(nrst),
        .baud_div(baud_div),
        .ticks(ticks)
    );

    // ---------------- Transmitter ----------------
    typedef enum logic [1:0] {ASR_TX_IDLE, ASR_TX_SHIFT} asr_tx_state_e;
    asr_tx_state_e tx_state_q;
    logic [8:0] tx_buf_q;
    logic tx_buf_full_q;
    logic [13:0] tx_shift_q;
    logic [3:0] tx_left_q;
    logic tx_en_q;
    logic sbk_q;
    logic idle_pend_q;
    logic brk_pend_q;
    logic tx_line;
    logic [3:0] frame_len;
    logic [3:0] break_len;
    logic tx_free;
    logic tx_load;
    logic tc_q;

    assign frame_len = nine_bit_select ? 4'(asr_pkg::FRAME_BITS_9) : 4'(asr_pkg::FRAME_BITS_8);
    assign break_len = frame_len + (long_break_select ? 4'(asr_pkg::LONG_BREAK_EXTRA) : 4'h0);

    // Edges of the enable and break controls queue idle and break frames
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tx_en_q <= 1'b0;
            sbk_q <= 1'b0;
            idle_pend_q <= 1'b0;
            brk_pend_q <= 1'b0;
        end else begin
            tx_en_q <= tx_enable;
            sbk_q <= send_break;
            if (tx_enable && !tx_en_q) begin
                idle_pend_q <= 1'b1;
            end else if (tx_free && !brk_pend_q) begin
                idle_pend_q <= 1'b0;
            end
            if (sbk_q && !send_break) begin
                brk_pend_q <= 1'b1;
            end else if (tx_free && brk_pend_q) begin
                brk_pend_q <= send_break;
            end
        end
    end

    // Buffer write; a write wins over the load into the shifter if both occur on one edge
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tx_buf_q <= asr_pkg::DATA_RESET;
            tx_buf_full_q <= 1'b0;
        end else begin
            if (tx_load) begin
                tx_buf_full_q <= 1'b0;
            end
            if (data_buffer_port_write) begin
                tx_buf_q <= {ninth_tx_bit, data_buffer_port_wdata};
                tx_buf_full_q <= 1'b1;
            end
        end
    end

    // The last bit tick of a frame is also a free slot, so frames follow with no gap
    assign tx_free = ticks.tick1_tx && (tx_state_q == ASR_TX_IDLE || tx_left_q == 4'h1);
    assign tx_load = tx_free && !brk_pend_q && !idle_pend_q && tx_buf_full_q && tx_enable;

    // Shifter: idle, break and data frames are all shifted LSB first
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tx_state_q <= ASR_TX_IDLE;
            tx_shift_q <= 14'h3fff;
            tx_left_q <= 4'h0;
            tc_q <= 1'b1;
        end else if (tx_free) begin
            if (brk_pend_q) begin
                tx_shift_q <= 14'h0000;
                tx_left_q <= break_len;
                tx_state_q <= ASR_TX_SHIFT;
                tc_q <= 1'b0;
            end else if (idle_pend_q) begin
                tx_shift_q <= 14'h3fff;
                tx_left_q <= frame_len;
                tx_state_q <= ASR_TX_SHIFT;
                tc_q <= 1'b0;
            end else if (tx_load) begin
                tx_shift_q <= nine_bit_select ? {3'h7, 1'b1, tx_buf_q, 1'b0}
                                              : {4'hf, 1'b1, tx_buf_q[7:0], 1'b0};
                tx_left_q <= frame_len;
                tx_state_q <= ASR_TX_SHIFT;
                tc_q <= 1'b0;
            end else begin
                tx_state_q <= ASR_TX_IDLE;
                tc_q <= 1'b1;
            end
        end else if (ticks.tick1_tx && tx_state_q == ASR_TX_SHIFT) begin
            tx_shift_q <= {1'b1, tx_shift_q[13:1]};
            tx_left_q <= tx_left_q - 4'h1;
        end
    end

    // Lags one edge so the flag never shows before the pin is back at idle
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tx_complete <= 1'b1;
        end else begin
            tx_complete <= tc_q;
        end
    end

    assign tx_line = (tx_state_q == ASR_TX_SHIFT) ? tx_shift_q[0] : 1'b1;
    assign tx_buffer_empty = !tx_buf_full_q;

    // Pin held while enabled, while an idle or break frame is queued, or while any frame is shifting
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            txd <= 1'b1;
            txd_oe <= 1'b0;
        end else begin
            txd <= tx_line ^ tx_polarity_invert;
            txd_oe <= tx_enable || tx_state_q == ASR_TX_SHIFT
                      || brk_pend_q || idle_pend_q || !tx_complete;
        end
    end

    // ---------------- Receiver ----------------
    typedef enum logic [1:0] {ASR_RX_HUNT, ASR_RX_START, ASR_RX_BITS} asr_rx_state_e;
    asr_rx_state_e rx_state_q;
    logic rx_sample;
    logic rx_fall;
    logic preload_q;
    logic [3:0] slot_q;
    logic [3:0] bit_q;
    logic [2:0] votes_q;
    logic [1:0] start_zeros_q;
    logic noise_q;
    logic [9:0] rx_shift_q;
    logic bit_val;
    logic [3:0] last_bit;
    logic rd_armed_q;

    asr_rx_sampler u_samp (
        .mclk(mclk),
        .nrst(nrst),
        .rxd(rxd),
        .rx_polarity_invert(rx_polarity_invert),
        .tick16(ticks.tick16 && rx_enable),
        .preload_ones(preload_q),
        .sample(rx_sample),
        .fall_edge(rx_fall)
    );

    assign bit_val = (votes_q[0] & votes_q[1]) | (votes_q[0] & votes_q[2])
                     | (votes_q[1] & votes_q[2]);
    assign last_bit = nine_bit_select ? 4'ha : 4'h9;
    assign rx_active = rx_state_q != ASR_RX_HUNT;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rx_state_q <= ASR_RX_HUNT;
            slot_q <= 4'h0;
            bit_q <= 4'h0;
            votes_q <= 3'h0;
            start_zeros_q <= 2'h0;
            noise_q <= 1'b0;
            rx_shift_q <= 10'h000;
            preload_q <= 1'b0;
        end else if (!rx_enable) begin
            rx_state_q <= ASR_RX_HUNT;
            preload_q <= 1'b0;
        end else begin
            preload_q <= 1'b0;
            if (ticks.tick16) begin
                slot_q <= slot_q + 4'h1;
                if (rx_fall && (rx_state_q == ASR_RX_HUNT
                    || slot_q >= asr_pkg::SLOT_EDGE_WINDOW)) begin
                    slot_q <= 4'h1;
                    if (rx_state_q == ASR_RX_HUNT) begin
                        rx_state_q <= ASR_RX_START;
                        start_zeros_q <= 2'h0;
                        noise_q <= 1'b0;
                        bit_q <= 4'h0;
                    end
                end
                if (rx_state_q == ASR_RX_START) begin
                    if (slot_q == asr_pkg::SLOT_EDGE_CHECK_A || slot_q == asr_pkg::SLOT_EDGE_CHECK_B
                        || slot_q == asr_pkg::SLOT_EDGE_CHECK_C) begin
                        if (!rx_sample) begin
                            start_zeros_q <= start_zeros_q + 2'h1;
                        end else begin
                            noise_q <= 1'b1;
                        end
                    end
                    if (slot_q == asr_pkg::SLOT_EDGE_CHECK_C) begin
                        if (start_zeros_q + (rx_sample ? 2'h0 : 2'h1) >= 2'h2) begin
                            rx_state_q <= ASR_RX_BITS;
                        end else begin
                            rx_state_q <= ASR_RX_HUNT;
                        end
                    end
                end
                if (rx_state_q == ASR_RX_BITS) begin
                    if (slot_q == asr_pkg::SLOT_VOTE_A) votes_q[0] <= rx_sample;
                    if (slot_q == asr_pkg::SLOT_VOTE_B) votes_q[1] <= rx_sample;
                    if (slot_q == asr_pkg::SLOT_VOTE_C) begin
                        votes_q[2] <= rx_sample;
                    end
                    if (slot_q == asr_pkg::SLOT_VOTE_C + 4'h1) begin
                        if (votes_q != 3'h0 && votes_q != 3'h7 && bit_q != 4'h0) begin
                            noise_q <= 1'b1;
                        end
                        if (bit_q != 4'h0) begin
                            rx_shift_q <= {bit_val, rx_shift_q[9:1]};
                        end
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == last_bit) begin
                            rx_state_q <= ASR_RX_HUNT;
                            preload_q <= !bit_val && (rx_shift_q[9:1] != 9'h000);
                        end
                    end
                end
            end
        end
    end

    // A completed frame is handed over when the last vote is decided
    logic rx_done;
    logic [8:0] rx_char;
    assign rx_done = rx_enable && ticks.tick16 && rx_state_q == ASR_RX_BITS
                     && slot_q == asr_pkg::SLOT_VOTE_C + 4'h1 && bit_q == last_bit;
    assign rx_char = nine_bit_select ? rx_shift_q[9:1] : {1'b0, rx_shift_q[9:2]};

    logic [8:0] rx_buf_q;
    logic rx_clear;
    assign rx_clear = rd_armed_q && data_buffer_port_read;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rd_armed_q <= 1'b0;
        end else if (status_one_reg_read && rx_buffer_full) begin
            rd_armed_q <= 1'b1;
        end else if (data_buffer_port_read) begin
            rd_armed_q <= 1'b0;
        end
    end

    // New arrivals win over a clear on the same edge
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rx_buf_q <= asr_pkg::DATA_RESET;
            rx_buffer_full <= 1'b0;
            overrun_flag <= 1'b0;
            noise_flag <= 1'b0;
            framing_error_flag <= 1'b0;
        end else begin
            if (rx_clear) begin
                rx_buffer_full <= 1'b0;
                overrun_flag <= 1'b0;
                noise_flag <= 1'b0;
            end
            if (error_clear) begin
                framing_error_flag <= 1'b0;
            end
            if (rx_done && !framing_error_flag) begin
                if (rx_buffer_full && !rx_clear) begin
                    overrun_flag <= 1'b1;
                end else if (!bit_val) begin
                    framing_error_flag <= 1'b1;
                end else begin
                    rx_buf_q <= {rx_char[8], rx_char[7:0]};
                    rx_buffer_full <= 1'b1;
                    noise_flag <= noise_q || (votes_q != 3'h0 && votes_q != 3'h7);
                end
            end
        end
    end

    assign data_buffer_port_rdata = rx_buf_q[7:0];
    assign ninth_rx_bit = rx_buf_q[8];
endmodule

// file: verilog/asr_pkg.sv
// Constants shared by the serial transceiver core
package asr_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned PRESCALE = 4;
    localparam int unsigned OVERSAMPLE = 16;
    localparam int unsigned FRAME_BITS_8 = 10;
    localparam int unsigned FRAME_BITS_9 = 11;
    localparam int unsigned LONG_BREAK_EXTRA = 3;
    localparam logic [12:0] BAUD_DIV_RESET = 13'h001a;
    localparam logic [3:0] SLOT_EDGE_CHECK_A = 4'h2;
    localparam logic [3:0] SLOT_EDGE_CHECK_B = 4'h4;
    localparam logic [3:0] SLOT_EDGE_CHECK_C = 4'h6;
    localparam logic [3:0] SLOT_VOTE_A = 4'h7;
    localparam logic [3:0] SLOT_VOTE_B = 4'h8;
    localparam logic [3:0] SLOT_VOTE_C = 4'h9;
    localparam logic [3:0] SLOT_LAST = 4'hf;
    localparam logic [3:0] SLOT_EDGE_WINDOW = 4'hb;
    localparam logic [8:0] DATA_RESET = 9'h000;
endpackage

// file: verilog/asr_rx_sampler.sv
// Receive input synchroniser, polarity and falling edge history
`timescale 1ns/1ps
module asr_rx_sampler (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic rxd,
    input wire logic rx_polarity_invert,
    input wire logic tick16,
    input wire logic preload_ones,
    output logic sample,
    output logic fall_edge
);
    logic s1_q;
    logic s2_q;
    logic [2:0] hist_q;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
        end else begin
            s1_q <= rxd;
            s2_q <= s1_q;
        end
    end

    assign sample = s2_q ^ rx_polarity_invert;
    assign fall_edge = tick16 && (hist_q == 3'h7) && !sample;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hist_q <= 3'h0;
        end else if (preload_ones) begin
            hist_q <= 3'h7;
        end else if (tick16) begin
            hist_q <= {hist_q[1:0], sample};
        end
    end
endmodule

// file: verilog/asr_tick_if.sv
// Baud tick carrier between the core and its rate generator
`timescale 1ns/1ps
interface asr_tick_if;
    logic tick16;
    logic tick1_tx;
    modport gen (output tick16, output tick1_tx);
    modport use_side (input tick16, input tick1_tx);
endinterface
